// File: hdl/rtcdv_pkg.sv
// Overview of operation
// (RULE1) year tens digit held in bits 31-28
// (RULE2) year units digit held in bits 27-24
// (RULE3) month tens digit held in bit 20
// (RULE4) month units digit held in bits 19-16
// (RULE5) day tens digit held in bits 13-12
// (RULE6) day units digit held in bits 11-8
// (RULE7) weekday number held in bits 2-0
// (RULE8) date writable only while write unlock set
// (RULE9) unused bits read zero, writes ignored
// (RULE10) locked write changes nothing, reports okay
package rtcdv_pkg;
    localparam logic [31:0] RTCDV_DATE_OFS = 32'h0000_0000;
    localparam logic [31:0] RTCDV_CTRL_OFS = 32'h0000_0004;
    localparam int RTCDV_UNLOCK_BIT = 3;
    localparam logic [31:0] RTCDV_DATE_MASK = 32'hFF1F_3F07;
    localparam logic [31:0] RTCDV_CTRL_MASK = 32'h0000_0008;
    localparam logic [31:0] RTCDV_DATE_RST = 32'h0000_0000;
    localparam logic [31:0] RTCDV_CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] RTCDV_RESP_OKAY = 2'h0;
    localparam logic [1:0] RTCDV_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] year_tens_digit;
        logic [3:0] year_units_digit;
        logic [2:0] pad_23_21;
        logic month_tens_digit;
        logic [3:0] month_units_digit;
        logic [1:0] pad_15_14;
        logic [1:0] day_tens_digit;
        logic [3:0] day_units_digit;
        logic [4:0] pad_7_3;
        logic [2:0] weekday_number;
    } rtcdv_date_s;
endpackage : rtcdv_pkg

// File: hdl/rtcdv_date_reg.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rtcdv_date_reg (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output rtcdv_pkg::rtcdv_date_s o_date,
    output logic o_clock_write_unlock
);
    import rtcdv_pkg::*;

    ////////////////////////////////////////////////////////////////
    logic aw_held_r;
    logic [31:0] awaddr_r;
    logic w_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [31:0] date_r;
    logic [31:0] ctrl_r;
    logic [31:0] wmask;
    logic do_write;

    // each channel is taken once per write; the response waits for both
    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready = !w_held_r && !o_bvalid;
    assign do_write = aw_held_r && w_held_r && !o_bvalid;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
        end else if (i_awvalid && o_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= i_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // unlock bit steers whether the date word accepts writes
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= RTCDV_CTRL_RST;
        end else if (do_write && awaddr_r[31:2] == RTCDV_CTRL_OFS[31:2]) begin
            ctrl_r <= (ctrl_r & ~(wmask & RTCDV_CTRL_MASK)) | (wdata_r & wmask & RTCDV_CTRL_MASK);
        end
    end

    // field layout fixed by the struct; mask keeps unused bits at zero
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            date_r <= RTCDV_DATE_RST;
        end else if (do_write && awaddr_r[31:2] == RTCDV_DATE_OFS[31:2] && ctrl_r[RTCDV_UNLOCK_BIT]) begin // RULE8
            date_r <= (date_r & ~(wmask & RTCDV_DATE_MASK)) | (wdata_r & wmask & RTCDV_DATE_MASK); // RULE9
        end
    end

    assign o_date = rtcdv_date_s'(date_r); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
    assign o_clock_write_unlock = ctrl_r[RTCDV_UNLOCK_BIT];

    ////////////////////////////////////////////////////////////////
    // locked date writes still answer okay; only unmapped slots error
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bvalid <= 1'b0;
            o_bresp <= RTCDV_RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            if (awaddr_r[31:2] == RTCDV_DATE_OFS[31:2]) begin
                o_bresp <= RTCDV_RESP_OKAY; // RULE10
            end else if (awaddr_r[31:2] == RTCDV_CTRL_OFS[31:2]) begin
                o_bresp <= RTCDV_RESP_OKAY;
            end else begin
                o_bresp <= RTCDV_RESP_SLVERR;
            end
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign o_arready = !o_rvalid;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RTCDV_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            if (i_araddr[31:2] == RTCDV_DATE_OFS[31:2]) begin
                o_rdata <= date_r & RTCDV_DATE_MASK; // RULE9
                o_rresp <= RTCDV_RESP_OKAY;
            end else if (i_araddr[31:2] == RTCDV_CTRL_OFS[31:2]) begin
                o_rdata <= ctrl_r & RTCDV_CTRL_MASK;
                o_rresp <= RTCDV_RESP_OKAY;
            end else begin
                o_rdata <= 32'h0000_0000;
                o_rresp <= RTCDV_RESP_SLVERR;
            end
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule // rtcdv_date_reg
`default_nettype wire

// File: tb/rtcdv_date_reg_props.sv
`timescale 1ns/1ps
`default_nettype none
module rtcdv_date_reg_props (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_bready,
    input wire logic i_rready,
    input wire logic o_bvalid,
    input wire logic o_rvalid,
    input wire rtcdv_pkg::rtcdv_date_s o_date,
    input wire logic o_clock_write_unlock);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    property p_pad; (o_date & 32'h00E0_C0F8) == 0; endproperty // literal mask, not the package one
    a_pad: assert property (p_pad) else $error("unused date bit set");
    property p_lk; !o_clock_write_unlock |=> $stable(o_date); endproperty
    a_lk: assert property (p_lk) else $error("date moved while locked");
    property p_ch; $changed(o_date) |-> $rose(o_bvalid) && $past(o_clock_write_unlock); endproperty
    a_ch: assert property (p_ch) else $error("date moved without write");
    property p_ul; $changed(o_clock_write_unlock) |-> $rose(o_bvalid); endproperty
    a_ul: assert property (p_ul) else $error("unlock moved without write");
    property p_rs; o_rvalid && !i_rready |=> o_rvalid; endproperty
    a_rs: assert property (p_rs) else $error("rvalid dropped early");
    property p_rd; o_rvalid && i_rready |=> !o_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("rvalid stuck");
    property p_bs; o_bvalid && !i_bready |=> o_bvalid; endproperty
    a_bs: assert property (p_bs) else $error("bvalid dropped early");
    property p_bd; o_bvalid && i_bready |=> !o_bvalid; endproperty
    a_bd: assert property (p_bd) else $error("bvalid stuck");
    cover property ($rose(o_bvalid) && !$past(o_clock_write_unlock));
    cover property ($changed(o_date));
    cover property ($rose(o_rvalid));
endmodule // rtcdv_date_reg_props
bind rtcdv_date_reg rtcdv_date_reg_props props_u (.*);
`default_nettype wire

// File: tb/test_rtcdv_date_reg.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtcdv_date_reg;
    logic i_mclk = 1'h0, i_rstn = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0;
    logic i_rready = 1'h0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_clock_write_unlock;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata;
    logic [3:0] i_wstrb = 4'hF;
    logic [1:0] o_bresp, o_rresp;
    rtcdv_pkg::rtcdv_date_s o_date;
    int fail_count = 0, total_checks = 0;
    rtcdv_date_reg dut_u (.*);
    always #2.5 i_mclk = ~i_mclk;
    task automatic chk(input string n, input logic [33:0] s, x);
        total_checks++;
        if (s !== x) fail_count++;
        if (s !== x) $display("MISMATCH %s exp %h seen %h", n, x, s);
    endtask
    task automatic summarize(input int extra);
        fail_count += extra;
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // write, then read back; ready is looked at on the falling edge, clear of the launch edge
    task automatic wrd(input logic [31:0] a, d, e, input logic [1:0] x);
        @(posedge i_mclk);
        {i_awaddr, i_araddr, i_wdata} <= {a, a, d};
        {i_awvalid, i_wvalid, i_rready} <= 3'h6;
        do @(negedge i_mclk); while ({o_awready, o_wready} !== 2'h3);
        @(posedge i_mclk);
        {i_awvalid, i_wvalid} <= 2'h0;
        do @(negedge i_mclk); while (o_bvalid !== 1'h1);
        chk("bresp", o_bresp, x);
        @(posedge i_mclk);
        {i_bready, i_arvalid} <= 2'h3;
        do @(negedge i_mclk); while (o_arready !== 1'h1);
        @(posedge i_mclk);
        {i_bready, i_arvalid, i_rready} <= 3'h1;
        do @(negedge i_mclk); while (o_rvalid !== 1'h1);
        chk("read", {o_rresp, o_rdata}, {x, e});
    endtask
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rstn <= 1'h1;
        wrd(32'h0, 32'h2107_1203, 32'h0, 2'h0);
        wrd(32'h4, 32'hFFFF_FFFF, 32'h8, 2'h0);
        wrd(32'h0, 32'h99F2_F1FE, 32'h9912_3106, 2'h0);
        chk("date_port", o_date, 32'h9912_3106);
        chk("unlock_port", o_clock_write_unlock, 1'h1);
        // relock, then a date write must leave every field alone
        wrd(32'h4, 32'h0, 32'h0, 2'h0);
        chk("unlock_port", o_clock_write_unlock, 1'h0);
        wrd(32'h0, 32'h1111_1111, 32'h9912_3106, 2'h0);
        chk("date_port", o_date, 32'h9912_3106);
        wrd(32'h8, 32'h1, 32'h0, 2'h2);
        summarize(0);
    end
    initial #3000 summarize(1);
endmodule // test_rtcdv_date_reg
`default_nettype wire
